/* spc_params.svh */
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

`define SPC_CLK_HZ        25000000
`define SPC_CLK_PERIOD_NS 40
`define SPC_MAX_PPS       10000
`define SPC_MIN_PPS       1
`define SPC_START_SHIFT   3
`define SPC_PULSE_NS      5000
`define SPC_PULSE_CYC \
  ((`SPC_PULSE_NS + `SPC_CLK_PERIOD_NS - 1) / `SPC_CLK_PERIOD_NS)

`define SPC_OFF_CMD    8'h00
`define SPC_OFF_ARG0   8'h04
`define SPC_OFF_ARG1   8'h08
`define SPC_OFF_FLAGS  8'h0c
`define SPC_OFF_STATUS 8'h10
`define SPC_OFF_POS1   8'h14
`define SPC_OFF_POS2   8'h18
`define SPC_OFF_LEFT1  8'h1c
`define SPC_OFF_LEFT2  8'h20

`define SPC_CMD_OP_LSB  0
`define SPC_CMD_SEL_LSB 8
`define SPC_CMD_RLY_LSB 16

`define SPC_SEL_CTRL1 8'h01
`define SPC_SEL_FULL1 8'h0b
`define SPC_SEL_HALF1 8'h15
`define SPC_SEL_CTRL2 8'h20
`define SPC_CHAN1     8'h01
`define SPC_CHAN2     8'h02

`define SPC_RST_WORD  32'h0000_0000
`define SPC_RESP_OKAY 2'b00
`define SPC_RESP_SLV  2'b10

`endif

/* spc_pkg.sv */
`default_nettype none

package spc_pkg;

  typedef enum logic [1:0] {
    MODE_CTRL = 2'b00,
    MODE_FULL = 2'b01,
    MODE_HALF = 2'b10
  } spc_mode_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_ACCEL  = 2'b01,
    PH_CRUISE = 2'b10,
    PH_DECEL  = 2'b11
  } spc_phase_t;

  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_SETUP = 3'b001,
    OP_REL   = 3'b010,
    OP_ABS   = 3'b011,
    OP_ABORT = 3'b100,
    OP_HOME  = 3'b101,
    OP_SRST  = 3'b110
  } spc_op_t;

  typedef struct packed {
    logic      ok;
    logic      ch;
    spc_mode_t mode;
  } spc_sel_t;

  typedef struct packed {
    logic [13:0] rate;
    logic [31:0] ramp;
  } spc_prof_t;

endpackage

`default_nettype wire

/* spc_stepper_ctrl.sv */
// Notes on behaviour
// - Selector 11 gives full-step coil mode, 21 gives half-step coil mode.
// - Selector 1 puts channel one in direction/step controller mode.
// - Selector 32 runs channel two as controller on outputs seven, eight.
// - Channel one controller: direction on output five, pulses on six.
// - Coil modes use outputs five to eight as the four phases.
// - Profile survives soft reset, cleared only by power-on reset.
// - Setup takes channel 1 or 2 and rate 1 to 10000 pps.
// - Ramp gives steps to accelerate and steps to decelerate.
// - Trajectory computed from stored profile at every move start.
// - Channel two offers controller mode only.
// - Relative count magnitude gives pulses; negative reverses direction.
// - Half-step mode counts and positions are in half steps.
// - Move start clears its flag; completion sets it.
// - Absolute move derives count and direction from target minus position.
// - Positions are signed 32-bit values from home.
// - Home command sets the reference position to zero while the channel is idle; ignored while it moves.
// - Move commands ignored while channel moves, until done or aborted.
// - Position readable at any time, also while moving.
// - Direction output high for negative motion, low for positive.
// - Ramp starts and ends at one eighth of maximum rate.
`include "spc_params.svh"
`timescale 1ns/100ps
`default_nettype none

module spc_stepper_ctrl #(
  parameter int CLK_HZ    = `SPC_CLK_HZ,
  parameter int MAX_PPS   = `SPC_MAX_PPS,
  parameter int PULSE_CYC = `SPC_PULSE_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [3:0]       motor_out
);
  import spc_pkg::*;

  if (CLK_HZ >= (1 << 25) || CLK_HZ < 2 * MAX_PPS) begin : g_bad_clk
    $error("spc_stepper_ctrl: CLK_HZ out of range");
  end
  if (MAX_PPS < 1 || MAX_PPS > 16383) begin : g_bad_pps
    $error("spc_stepper_ctrl: MAX_PPS out of range");
  end
  if (PULSE_CYC < 8 || PULSE_CYC > 127) begin : g_bad_pulse
    $error("spc_stepper_ctrl: PULSE_CYC out of range");
  end

  localparam logic [25:0] CLK26  = 26'(CLK_HZ);
  localparam logic [13:0] PPS_HI = 14'(MAX_PPS);
  localparam logic [13:0] PPS_LO = 14'(`SPC_MIN_PPS);
  localparam logic [6:0]  PW     = 7'(PULSE_CYC);

  function automatic spc_sel_t decode_sel(input logic [7:0] s);
    spc_sel_t r;
    r = '{ok: 1'b1, ch: 1'b0, mode: MODE_CTRL};
    unique case (s)
      `SPC_SEL_CTRL1: r.mode = MODE_CTRL;
      `SPC_SEL_FULL1: r.mode = MODE_FULL;
      `SPC_SEL_HALF1: r.mode = MODE_HALF;
      `SPC_SEL_CTRL2: r.ch = 1'b1;
      default:        r.ok = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] coil_pattern(input logic [2:0] idx);
    logic [3:0] p;
    unique case (idx)
      3'h0: p = 4'h1;
      3'h1: p = 4'h5;
      3'h2: p = 4'h4;
      3'h3: p = 4'h6;
      3'h4: p = 4'h2;
      3'h5: p = 4'ha;
      3'h6: p = 4'h8;
      3'h7: p = 4'h9;
    endcase
    return p;
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Register bus
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_go;
  logic        wr_hit;
  logic [31:0] arg0;
  logic [31:0] arg1;
  logic [31:0] flags;
  logic        cmd_err;

  // Channel state
  spc_prof_t   prof    [2];
  logic [1:0]  prof_ok;
  spc_phase_t  ph      [2];
  logic [32:0] remain  [2];
  logic [31:0] pos     [2];
  logic [1:0]  dir;
  logic [24:0] acc     [2];
  logic [13:0] rate    [2];
  logic [31:0] owe     [2];
  logic [6:0]  pulse   [2];
  logic [4:0]  relay   [2];
  spc_mode_t   ch0_mode;
  logic [2:0]  coil_idx;

  // Decoded command
  spc_op_t     op;
  spc_sel_t    sel;
  logic [7:0]  sel_raw;
  logic        cmd_go;
  logic [1:0]  setup;
  logic [1:0]  mv_req;
  logic [1:0]  start;
  logic [1:0]  abort;
  logic [1:0]  home;
  logic        srst;
  logic [1:0]  step_ev;
  logic [1:0]  done;
  logic [32:0] mag     [2];
  logic [1:0]  neg;
  logic [13:0] min_r   [2];
  logic [13:0] span    [2];
  logic [25:0] sum     [2];
  logic [32:0] diff;
  logic [32:0] ext0;

  assign s_axi_awready = !aw_hold;
  assign s_axi_wready  = !w_hold;
  assign wr_go   = aw_hold && w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= `SPC_RST_WORD;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_hold) begin
        aw_hold <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && !w_hold) begin
        w_hold  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case ({wr_addr[7:2], 2'b00})
      `SPC_OFF_CMD, `SPC_OFF_ARG0, `SPC_OFF_ARG1,
      `SPC_OFF_FLAGS: wr_hit = 1'b1;
      default:        wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SPC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `SPC_RESP_OKAY : `SPC_RESP_SLV;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      arg0 <= `SPC_RST_WORD;
      arg1 <= `SPC_RST_WORD;
    end else if (wr_go && {wr_addr[7:2], 2'b00} == `SPC_OFF_ARG0) begin
      arg0 <= merge_bytes(arg0, wr_data, wr_strb);
    end else if (wr_go && {wr_addr[7:2], 2'b00} == `SPC_OFF_ARG1) begin
      arg1 <= merge_bytes(arg1, wr_data, wr_strb);
    end
  end

  // Command decode
  always_comb begin
    op      = spc_op_t'(wr_data[`SPC_CMD_OP_LSB +: 3]);
    sel_raw = wr_data[`SPC_CMD_SEL_LSB +: 8];
    sel     = decode_sel(sel_raw);
    cmd_go  = wr_go && {wr_addr[7:2], 2'b00} == `SPC_OFF_CMD;
    srst    = cmd_go && op == OP_SRST;
    ext0    = {arg0[31], arg0};
    diff    = ext0 - {pos[0][31], pos[0]};
    for (int c = 0; c < 2; c++) begin
      setup[c] = cmd_go && op == OP_SETUP &&
                 sel_raw == (c == 0 ? `SPC_CHAN1 : `SPC_CHAN2) &&
                 arg0[31:14] == 18'h00000 &&
                 arg0[13:0] >= PPS_LO && arg0[13:0] <= PPS_HI;
      abort[c] = cmd_go && op == OP_ABORT &&
                 sel_raw == (c == 0 ? `SPC_CHAN1 : `SPC_CHAN2);
      home[c]  = cmd_go && op == OP_HOME &&
                 sel_raw == (c == 0 ? `SPC_CHAN1 : `SPC_CHAN2);
      // Channel two shares outputs seven and eight with the coils
      mv_req[c] = cmd_go && (op == OP_REL || op == OP_ABS) && sel.ok &&
                  sel.ch == 1'(c) && prof_ok[c] &&
                  (c == 0 ? (sel.mode == MODE_CTRL || ph[1] == PH_IDLE)
                          : ch0_mode == MODE_CTRL);
      start[c] = mv_req[c] && ph[c] == PH_IDLE;
      min_r[c] = (prof[c].rate >> `SPC_START_SHIFT) == 14'h0000 ?
                 PPS_LO : prof[c].rate >> `SPC_START_SHIFT;
      span[c]  = prof[c].rate - min_r[c];
      sum[c]   = {1'b0, acc[c]} + {12'h000, rate[c]};
      // A step due in the abort cycle is dropped, pulse and count alike
      step_ev[c] = ph[c] != PH_IDLE && sum[c] >= CLK26 &&
                   !abort[c] && !srst;
    end
    // Same count for either channel; the target is per channel
    if (op == OP_ABS) begin
      diff = sel.ch ? ext0 - {pos[1][31], pos[1]} : diff;
      neg  = {2{diff[32]}};
      mag[0] = diff[32] ? 33'(-diff) : diff;
    end else begin
      neg  = {2{arg0[31]}};
      mag[0] = arg0[31] ? 33'(-ext0) : ext0;
    end
    mag[1] = mag[0];
    for (int c = 0; c < 2; c++) begin
      done[c] = (step_ev[c] && remain[c] == 33'h1) ||
                (start[c] && mag[c] == 33'h0);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prof_ok <= 2'b00;
      for (int c = 0; c < 2; c++) begin
        prof[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (setup[c]) begin
          prof[c] <= '{rate: arg0[13:0], ramp: arg1};
          prof_ok[c] <= 1'b1;
        end
      end
    end
  end

  // Motion engine, one per channel
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dir <= 2'b00;
      for (int c = 0; c < 2; c++) begin
        ph[c]     <= PH_IDLE;
        remain[c] <= 33'h0;
        pos[c]    <= 32'h0;
        acc[c]    <= 25'h0;
        rate[c]   <= 14'h0;
        owe[c]    <= 32'h0;
        pulse[c]  <= 7'h0;
        relay[c]  <= 5'h0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (pulse[c] != 7'h0) begin
          pulse[c] <= pulse[c] - 7'h1;
        end
        if (srst || abort[c]) begin
          ph[c] <= PH_IDLE;
        end else if (start[c]) begin
          remain[c] <= mag[c];
          dir[c]    <= neg[c];
          relay[c]  <= wr_data[`SPC_CMD_RLY_LSB +: 5];
          acc[c]    <= 25'h0;
          owe[c]    <= 32'h0;
          rate[c]   <= prof[c].ramp == 32'h0 ?
                       prof[c].rate : min_r[c];
          ph[c]     <= mag[c] == 33'h0 ? PH_IDLE : PH_ACCEL;
        end else if (ph[c] != PH_IDLE) begin
          acc[c] <= step_ev[c] ? 25'(sum[c] - CLK26) : sum[c][24:0];
          // Ramp steps pay out one rate unit per clock, far faster
          // than steps come, so the slope follows span/ramp per step
          owe[c] <= owe[c] + (step_ev[c] ? {18'h0, span[c]} : 32'h0) -
                    ((owe[c] >= prof[c].ramp && prof[c].ramp != 32'h0) ?
                     prof[c].ramp : 32'h0);
          if (owe[c] >= prof[c].ramp && prof[c].ramp != 32'h0) begin
            if (ph[c] == PH_DECEL) begin
              rate[c] <= rate[c] > min_r[c] ? rate[c] - 14'h1 : min_r[c];
            end else if (rate[c] < prof[c].rate) begin
              rate[c] <= rate[c] + 14'h1;
            end
          end
          if (step_ev[c]) begin
            remain[c] <= remain[c] - 33'h1;
            pos[c]    <= dir[c] ? pos[c] - 32'h1 : pos[c] + 32'h1;
            pulse[c]  <= PW;
          end
          priority case (1'b1)
            step_ev[c] && remain[c] == 33'h1: ph[c] <= PH_IDLE;
            remain[c] <= {1'b0, prof[c].ramp}: ph[c] <= PH_DECEL;
            rate[c] >= prof[c].rate: ph[c] <= PH_CRUISE;
            default: ph[c] <= PH_ACCEL;
          endcase
        end else if (home[c]) begin
          pos[c] <= 32'h0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ch0_mode <= MODE_CTRL;
      coil_idx <= 3'h1;
    end else if (start[0]) begin
      ch0_mode <= sel.mode;
      coil_idx <= sel.mode == MODE_FULL ? coil_idx | 3'h1 : coil_idx;
    end else if (step_ev[0] && ch0_mode != MODE_CTRL) begin
      coil_idx <= coil_idx + (dir[0] ?
                  (ch0_mode == MODE_FULL ? 3'h6 : 3'h7) :
                  (ch0_mode == MODE_FULL ? 3'h2 : 3'h1));
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      motor_out <= 4'h0;
    end else if (ch0_mode != MODE_CTRL) begin
      motor_out <= coil_pattern(coil_idx);
    end else begin
      motor_out <= {pulse[1] != 7'h0, dir[1],
                    pulse[0] != 7'h0, dir[0]};
    end
  end

  // Flags: hardware set beats software write-one-to-clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags   <= 32'h0;
      cmd_err <= 1'b0;
    end else begin
      logic [31:0] clr;
      logic [31:0] set;
      clr = (wr_go && {wr_addr[7:2], 2'b00} == `SPC_OFF_FLAGS) ?
            merge_bytes(32'h0, wr_data, wr_strb) : 32'h0;
      set = 32'h0;
      for (int c = 0; c < 2; c++) begin
        if (start[c]) begin
          clr[wr_data[`SPC_CMD_RLY_LSB +: 5]] = 1'b1;
        end
        if (done[c]) begin
          set[start[c] ? wr_data[`SPC_CMD_RLY_LSB +: 5] : relay[c]] = 1'b1;
        end
      end
      flags <= (flags & ~clr) | set;
      if (cmd_go) begin
        cmd_err <= !(|{setup, start, abort, home, srst}) && op != OP_NONE;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `SPC_RST_WORD;
      s_axi_rresp  <= `SPC_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `SPC_RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `SPC_OFF_CMD:    s_axi_rdata <= `SPC_RST_WORD;
        `SPC_OFF_ARG0:   s_axi_rdata <= arg0;
        `SPC_OFF_ARG1:   s_axi_rdata <= arg1;
        `SPC_OFF_FLAGS:  s_axi_rdata <= flags;
        `SPC_OFF_STATUS: s_axi_rdata <= {23'h0, cmd_err, ch0_mode,
                                         prof_ok, ph[1] != PH_IDLE,
                                         ph[0] != PH_IDLE, ph[0]};
        `SPC_OFF_POS1:   s_axi_rdata <= pos[0];
        `SPC_OFF_POS2:   s_axi_rdata <= pos[1];
        `SPC_OFF_LEFT1:  s_axi_rdata <= remain[0][31:0];
        `SPC_OFF_LEFT2:  s_axi_rdata <= remain[1][31:0];
        default: begin
          s_axi_rdata <= `SPC_RST_WORD;
          s_axi_rresp <= `SPC_RESP_SLV;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_last_step0;
    step_ev[0] && remain[0] == 33'h1;
  endsequence
  sequence s_neg_start0;
    start[0] && neg[0] && mag[0] != 33'h0;
  endsequence

  a_flag_set_done: assert property (
    s_last_step0 |=> flags[relay[0]] && ph[0] == PH_IDLE)
    else $error("flag not set at move end");
  a_flag_clear_start: assert property (
    (start[0] && mag[0] != 33'h0 && !done[1]) |=>
      !flags[$past(wr_data[20:16])])
    else $error("flag not cleared at move start");
  a_busy_ignore: assert property (
    (mv_req[0] && ph[0] != PH_IDLE && !abort[0] && !srst) |=>
      $stable(relay[0]) && $stable(dir[0]))
    else $error("move accepted while busy");
  a_dir_negative: assert property (
    (s_neg_start0 and (ch0_mode == MODE_CTRL && sel.mode == MODE_CTRL)) |=>
      dir[0] ##1 motor_out[0])
    else $error("direction not high for negative move");
  a_pulse_width: assert property (
    (ch0_mode == MODE_CTRL && $rose(motor_out[1])) |-> motor_out[1][*8])
    else $error("step pulse too short");
  a_pos_track: assert property (
    step_ev[0] |=> pos[0] == ($past(dir[0]) ? $past(pos[0]) - 32'h1
                                            : $past(pos[0]) + 32'h1))
    else $error("position not tracking steps");
  a_rate_floor: assert property (
    ph[0] != PH_IDLE |-> rate[0] >= min_r[0] && rate[0] <= prof[0].rate)
    else $error("rate outside profile");
  a_profile_keep: assert property (
    srst |=> $stable(prof[0]) && $stable(prof_ok))
    else $error("soft reset disturbed profile");
  a_home_zero: assert property (
    (home[0] && ph[0] == PH_IDLE) |=> pos[0] == 32'h0)
    else $error("home did not zero position");
  a_coil_drive: assert property (
    ch0_mode != MODE_CTRL |=> motor_out == coil_pattern($past(coil_idx)))
    else $error("coil outputs wrong");

endmodule
`default_nettype wire

/* spc_drv_model.sv */
`timescale 1ns/100ps
`default_nettype none

module spc_drv_model (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] motor_out,
  output var  int         pos1,
  output var  int         pos2,
  output var  int         coil_chg
);
  logic [3:0] last;

  // Direction is taken at the step edge, as an external driver latches it
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      last <= 4'h0;
      pos1 <= 0;
      pos2 <= 0;
      coil_chg <= 0;
    end else begin
      last <= motor_out;
      if (motor_out[1] && !last[1]) begin
        pos1 <= motor_out[0] ? pos1 - 1 : pos1 + 1;
      end
      if (motor_out[3] && !last[3]) begin
        pos2 <= motor_out[2] ? pos2 - 1 : pos2 + 1;
      end
      // Coil windings: every pattern change is one step
      if (motor_out != last) begin
        coil_chg <= coil_chg + 1;
      end
    end
  end
endmodule

`default_nettype wire

/* stepper_pulse_controller_tb.sv */
`include "spc_params.svh"
`timescale 1ns/100ps
`default_nettype none

module stepper_pulse_controller_tb;
  import spc_pkg::*;
  typedef struct {
    logic [1:0]  r;
    logic [31:0] d;
    logic [31:0] m;
    string       s;
  } spc_note_t;
  spc_note_t   q[$];
  spc_note_t   nt;
  logic        core_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, sel;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  motor_out, s_axi_wstrb, pat;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  int          n_errors, compares, cyc, p1, p2, cc, i, e2, c0;

  always #20 core_clk = ~core_clk;

  // Short clock rate keeps step periods at tens of cycles
  spc_stepper_ctrl #(.CLK_HZ(100000), .MAX_PPS(10000), .PULSE_CYC(8)) DUT (
    .core_clk, .arst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .motor_out);

  spc_drv_model FAR (.core_clk, .arst_n, .motor_out, .pos1(p1), .pos2(p2),
                     .coil_chg(cc));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic end_sim;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Responses are settled at the falling edge
  always @(negedge core_clk) begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      nt = q.pop_front();
      if (s_axi_bvalid) chk({nt.s, " bresp"}, 32'(nt.r), 32'(s_axi_bresp));
      if (s_axi_rvalid) chk({nt.s, " rresp"}, 32'(nt.r), 32'(s_axi_rresp));
      if (s_axi_rvalid && nt.m != 0) chk(nt.s, nt.d & nt.m, s_axi_rdata & nt.m);
    end
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      end_sim;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'b00);
    logic at, wt, bt;
    q.push_back('{r, 32'h0, 32'h0, "wr"});
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge core_clk);
      at = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      bt = s_axi_bvalid;
      @(posedge core_clk);
      if (at) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
    end while (!bt);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input string s,
                    input logic [1:0] r = 2'b00);
    logic at, bt;
    q.push_back('{r, e, m, s});
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge core_clk);
      at = s_axi_arvalid && s_axi_arready;
      bt = s_axi_rvalid;
      v = s_axi_rdata;
      @(posedge core_clk);
      if (at) s_axi_arvalid <= 1'b0;
    end while (!bt);
    s_axi_rready <= 1'b0;
  endtask

  task automatic go(input logic [2:0] op, input logic [7:0] sl, input int arg,
                    input logic [4:0] fl);
    wr(`SPC_OFF_ARG0, arg);
    wr(`SPC_OFF_CMD, {11'h0, fl, sl, 5'h0, op});
  endtask

  task automatic setup(input logic [7:0] ch, input int pps, input int ramp);
    wr(`SPC_OFF_ARG1, ramp);
    go(3'd1, ch, pps, 5'd0);
  endtask

  // Bounded by the global cycle ceiling
  task automatic wait_flag(input int b);
    do rd(`SPC_OFF_FLAGS, 0, 0, "flags"); while (v[b] !== 1'b1);
    // Far model sees the last pulse two edges after the flag rises
    repeat (2) @(posedge core_clk);
  endtask

  initial begin
    core_clk = 0;
    arst_n = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    s_axi_rready = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_wstrb, s_axi_awprot, s_axi_arprot} = '0;
    {n_errors, compares, cyc} = '0;
    v = $urandom(21058);
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    go(3'd2, `SPC_SEL_CTRL1, 5, 5'd0);
    rd(`SPC_OFF_STATUS, 32'h100, 32'h134, "status");
    for (i = 0; i < 2; i++) begin
      setup(`SPC_CHAN1, i * 10001, 0);
      rd(`SPC_OFF_STATUS, 32'h100, 32'h110, "status");
    end
    setup(`SPC_CHAN1, 5000, 0);
    setup(`SPC_CHAN2, 10000, 0);
    rd(`SPC_OFF_STATUS, 32'h030, 32'h130, "status");
    go(3'd2, `SPC_SEL_CTRL1, 5, 5'd3);
    wait_flag(3);
    chk("far pos1", 5, p1);
    go(3'd2, `SPC_SEL_CTRL1, -7, 5'd3);
    rd(`SPC_OFF_FLAGS, 0, 32'h8, "flag3");
    wait_flag(3);
    chk("far pos1", -2, p1);
    rd(`SPC_OFF_POS1, -2, '1, "pos1");
    go(3'd2, `SPC_SEL_CTRL1, 20, 5'd3);
    go(3'd3, `SPC_SEL_CTRL1, 100, 5'd3);
    rd(`SPC_OFF_STATUS, 32'h104, 32'h104, "status");
    repeat (60) @(posedge core_clk);
    rd(`SPC_OFF_POS1, 0, 0, "pos1");
    chk("moving pos1", 1, 32'($signed(v) > -2 && $signed(v) < 18));
    wait_flag(3);
    chk("far pos1", 18, p1);
    go(3'd3, `SPC_SEL_CTRL2, -75, 5'd4);
    wait_flag(4);
    chk("far pos2", -75, p2);
    rd(`SPC_OFF_POS2, -75, '1, "pos2");
    go(3'd3, `SPC_SEL_CTRL2, 10, 5'd4);
    wait_flag(4);
    chk("far pos2", 10, p2);
    e2 = 10;
    repeat (3) begin
      i = int'($urandom_range(40)) - 20;
      e2 += i;
      go(3'd2, `SPC_SEL_CTRL2, i, 5'd4);
      wait_flag(4);
      chk("far pos2", e2, p2);
    end
    // First step at one eighth rate alone costs 80 cycles here
    setup(`SPC_CHAN2, 10000, 4);
    c0 = cyc;
    go(3'd2, `SPC_SEL_CTRL2, 20, 5'd4);
    wait_flag(4);
    chk("ramp pos2", e2 + 20, p2);
    chk("ramp slower", 1, 32'(cyc - c0 > 270));
    go(3'd5, `SPC_CHAN1, 0, 5'd0);
    rd(`SPC_OFF_POS1, 0, '1, "pos1");
    go(3'd3, `SPC_SEL_CTRL1, 3, 5'd5);
    wait_flag(5);
    chk("far pos1", 21, p1);
    go(3'd2, `SPC_SEL_CTRL1, 200, 5'd6);
    repeat (100) @(posedge core_clk);
    go(3'd4, `SPC_CHAN1, 0, 5'd0);
    rd(`SPC_OFF_STATUS, 0, 32'h4, "status");
    rd(`SPC_OFF_FLAGS, 0, 32'h40, "flag6");
    go(3'd2, `SPC_SEL_CTRL1, 2, 5'd6);
    wait_flag(6);
    wr(`SPC_OFF_CMD, 32'h6);
    rd(`SPC_OFF_STATUS, 32'h30, 32'h30, "status");
    for (i = 0; i < 2; i++) begin
      sel = i ? `SPC_SEL_HALF1 : `SPC_SEL_FULL1;
      go(3'd2, sel, 4 + 4 * i, 5'd7);
      wait_flag(7);
      rd(`SPC_OFF_STATUS, 32'((i + 1) << 6), 32'hc0, "mode");
      pat = motor_out;
      c0 = cc;
      go(3'd2, sel, 4 + 4 * i, 5'd7);
      wait_flag(7);
      chk("coil steps", 4 + 4 * i, cc - c0);
      chk("coil cycle", 32'(pat), 32'(motor_out));
    end
    go(3'd2, `SPC_SEL_CTRL2, 5, 5'd8);
    rd(`SPC_OFF_STATUS, 32'h100, 32'h108, "status");
    arst_n <= 1'b0;
    @(posedge core_clk);
    arst_n <= 1'b1;
    rd(`SPC_OFF_STATUS, 0, 32'h30, "status");
    rd(8'h40, 0, 0, "unmapped", 2'b10);
    wr(8'h44, 32'h1, 2'b10);
    end_sim;
  end
endmodule

`default_nettype wire
